/* verilog/slepc_pkg.sv */
// constants and types for the serial lane emphasis and serializer pll control bank
// Operation
// - lane registers hold post-tap enable in bit 7, level 6:4, 0 to 12 dB
// - writing 0x04 to calibration register resets serializer pll calibration
// - calibration register resets to 0x00; 0x00 means normal pll operation
// - writing 0x4F to start-up register holds start-up circuit in reset
// - start-up register powers up as 0x0F; writing 0x00 gives normal operation
// - writing 0x80 to lock-loss register clears the sticky lock lost flag
// - lock-loss register resets to 0x00; flag then records lock loss normally
package slepc_pkg;

	localparam int unsigned LANES = 4;

	// register indices; the byte address is four times the index
	localparam logic [13:0] IDX_LANE0   = 14'h05C4;
	localparam logic [13:0] IDX_LANE1   = 14'h05C6;
	localparam logic [13:0] IDX_LANE2   = 14'h05C8;
	localparam logic [13:0] IDX_LANE3   = 14'h05CA;
	localparam logic [13:0] IDX_PLL_CAL = 14'h1222;
	localparam logic [13:0] IDX_START   = 14'h1228;
	localparam logic [13:0] IDX_LOL     = 14'h1262;
	localparam logic [13:0] IDX_IRQ_STS = 14'h1300;
	localparam logic [13:0] IDX_IRQ_MSK = 14'h1301;
	localparam logic [13:0] IDX_FLAG    = 14'h1302;

	// lane register fields
	localparam int unsigned LANE_EN_BIT = 7;
	localparam int unsigned LANE_LVL_LO = 4;
	localparam logic [2:0]  LVL_MAX     = 3'h4;

	// action codes and reset values
	localparam logic [7:0] CODE_NORMAL  = 8'h00;
	localparam logic [7:0] CAL_RESET    = 8'h04;
	localparam logic [7:0] START_RESET  = 8'h4F;
	localparam logic [7:0] START_RSTVAL = 8'h0F;
	localparam logic [7:0] LOL_CLEAR    = 8'h80;
	localparam logic [7:0] LANE_RSTVAL  = 8'h00;

	// interrupt status bits
	localparam int unsigned EV_LOCK_LOSS = 0;
	localparam int unsigned EV_BAD_CODE  = 1;
	localparam int unsigned EV_W         = 2;

	typedef struct packed {
		logic       post_en;
		logic [2:0] level;
	} slepc_lane_s;

	typedef struct packed {
		logic [LANES-1:0][7:0] lane;
		logic [7:0]            cal;
		logic [7:0]            start;
		logic [7:0]            lolc;
		logic                  flag;
		logic [EV_W-1:0]       sts;
		logic [EV_W-1:0]       msk;
		logic                  ack;
		logic [31:0]           rdat;
	} slepc_state_s;

endpackage : slepc_pkg

/* verilog/slepc_bank.sv */
// wishbone register bank for lane emphasis and serializer pll control
`timescale 1ns/1ps
module slepc_bank (
	// clock, reset, enable
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_i,
	input  wire logic                                 ce_i,
	// wishbone classic slave
	input  wire logic                                 cyc_i,
	input  wire logic                                 stb_i,
	input  wire logic                                 we_i,
	input  wire logic [15:0]                          adr_i,
	input  wire logic [3:0]                           sel_i,
	input  wire logic [31:0]                          dat_i,
	output logic      [31:0]                          dat_o,
	output logic                                      ack_o,
	// serializer pll
	input  wire logic                                 lock_loss_i,
	output logic                                      pll_cal_reset_o,
	output logic                                      startup_reset_o,
	output logic                                      lock_lost_flag_o,
	// lane drivers
	output slepc_pkg::slepc_lane_s [slepc_pkg::LANES-1:0] lane_cfg_o,
	// interrupt
	output logic                                      irq_o
);
	import slepc_pkg::*;

	slepc_state_s    s_q;
	slepc_state_s    s_d;
	logic            req;
	logic            wr;
	logic [13:0]     idx;
	logic [7:0]      wbyte;
	logic [EV_W-1:0] ev;
	logic            lol_clear;

	function automatic logic [13:0] lane_idx(input int unsigned n);
		lane_idx = IDX_LANE0 + 14'(2 * n);
	endfunction : lane_idx

	function automatic logic lane_bad(input logic [7:0] v);
		lane_bad = v[LANE_LVL_LO +: 3] > LVL_MAX;
	endfunction : lane_bad

	localparam slepc_state_s RST_STATE = '{
		lane:  {LANES{LANE_RSTVAL}},
		cal:   CODE_NORMAL,
		start: START_RSTVAL,
		lolc:  CODE_NORMAL,
		flag:  1'b0,
		sts:   '0,
		msk:   '0,
		ack:   1'b0,
		rdat:  '0
	};

	assign req       = cyc_i & stb_i;
	assign idx       = adr_i[15:2];
	assign wbyte     = dat_i[7:0];
	// a write lands at the edge where the master sees ack
	assign wr        = req & we_i & s_q.ack & sel_i[0];
	assign lol_clear = s_q.lolc == LOL_CLEAR;

	always_comb begin
		s_d = s_q;
		ev  = '0;
		ev[EV_LOCK_LOSS] = lock_loss_i;
		// one wait state, then ack for exactly one cycle
		s_d.ack = req & ~s_q.ack;
		if (req & ~s_q.ack) begin
			s_d.rdat = '0;
			for (int unsigned i = 0; i < LANES; i++) begin
				if (idx == lane_idx(i)) begin
					s_d.rdat[7:0] = s_q.lane[i];
				end
			end
			if (idx == IDX_PLL_CAL) begin
				s_d.rdat[7:0] = s_q.cal;
			end else if (idx == IDX_START) begin
				s_d.rdat[7:0] = s_q.start;
			end else if (idx == IDX_LOL) begin
				s_d.rdat[7:0] = s_q.lolc;
			end else if (idx == IDX_IRQ_STS) begin
				s_d.rdat[EV_W-1:0] = s_q.sts;
			end else if (idx == IDX_IRQ_MSK) begin
				s_d.rdat[EV_W-1:0] = s_q.msk;
			end else if (idx == IDX_FLAG) begin
				s_d.rdat[0] = s_q.flag;
			end
		end
		if (wr) begin
			for (int unsigned i = 0; i < LANES; i++) begin
				if (idx == lane_idx(i)) begin
					// reserved low nibble is kept as written
					s_d.lane[i] = wbyte;
					ev[EV_BAD_CODE] = lane_bad(wbyte);
				end
			end
			if (idx == IDX_PLL_CAL) begin
				s_d.cal = wbyte;
				ev[EV_BAD_CODE] = (wbyte != CODE_NORMAL) && (wbyte != CAL_RESET);
			end else if (idx == IDX_START) begin
				s_d.start = wbyte;
				ev[EV_BAD_CODE] = (wbyte != CODE_NORMAL) && (wbyte != START_RESET)
					&& (wbyte != START_RSTVAL);
			end else if (idx == IDX_LOL) begin
				s_d.lolc = wbyte;
				ev[EV_BAD_CODE] = (wbyte != CODE_NORMAL) && (wbyte != LOL_CLEAR);
			end else if (idx == IDX_IRQ_MSK) begin
				s_d.msk = wbyte[EV_W-1:0];
			end
		end
		// sticky lock flag: a new loss wins over a held clear
		if (lock_loss_i) begin
			s_d.flag = 1'b1;
		end else if (lol_clear) begin
			s_d.flag = 1'b0;
		end
		// write one to clear, a same-cycle event wins
		if (wr && idx == IDX_IRQ_STS) begin
			s_d.sts = s_q.sts & ~wbyte[EV_W-1:0];
		end
		s_d.sts = s_d.sts | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= RST_STATE;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign ack_o            = s_q.ack;
	assign dat_o            = s_q.rdat;
	assign pll_cal_reset_o  = s_q.cal == CAL_RESET;
	// any non-normal code keeps start-up held, so the power-up value holds it too
	assign startup_reset_o  = s_q.start != CODE_NORMAL;
	assign lock_lost_flag_o = s_q.flag;
	assign irq_o            = |(s_q.sts & s_q.msk);

	always_comb begin
		for (int unsigned i = 0; i < LANES; i++) begin
			lane_cfg_o[i].post_en = s_q.lane[i][LANE_EN_BIT];
			lane_cfg_o[i].level   = s_q.lane[i][LANE_LVL_LO +: 3];
		end
	end

	// checks hold while the enable stays high
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	sequence wr_code(logic [13:0] a, logic [7:0] v);
		wr && idx == a && wbyte == v;
	endsequence

	sequence wr_any(logic [13:0] a);
		wr && idx == a;
	endsequence

	ack_single_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	ack_answer_a: assert property (req && !ack_o |=> ack_o)
		else $error("request not answered in one cycle");

	lane_field_a: assert property (wr_any(IDX_LANE2) |=>
		lane_cfg_o[2].post_en == $past(wbyte[7]) && lane_cfg_o[2].level == $past(wbyte[6:4]))
		else $error("lane fields do not follow the write");

	cal_reset_a: assert property (wr_code(IDX_PLL_CAL, CAL_RESET) |=> pll_cal_reset_o)
		else $error("calibration reset not raised");

	cal_normal_a: assert property (wr_code(IDX_PLL_CAL, CODE_NORMAL) |=> !pll_cal_reset_o)
		else $error("calibration not back to normal");

	start_hold_a: assert property (wr_code(IDX_START, START_RESET) |=> startup_reset_o)
		else $error("start-up reset not held");

	start_free_a: assert property (wr_code(IDX_START, CODE_NORMAL) |=> !startup_reset_o)
		else $error("start-up not released");

	flag_clear_a: assert property (lol_clear && !lock_loss_i |=> !lock_lost_flag_o)
		else $error("lock flag not cleared");

	flag_set_a: assert property (lock_loss_i |=> lock_lost_flag_o)
		else $error("lock loss not recorded");

	action_keep_a: assert property (pll_cal_reset_o && !(wr && idx == IDX_PLL_CAL) |=>
		pll_cal_reset_o)
		else $error("calibration reset dropped without a write");

	// a clear or mask write in the next cycle may legally drop the line again
	irq_event_a: assert property (lock_loss_i && s_q.msk[EV_LOCK_LOSS] && !wr |=> irq_o)
		else $error("unmasked lock loss gave no interrupt");

endmodule : slepc_bank

/* verification/tb.sv */
// self-checking bench for the lane emphasis and serializer pll control bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb;
	import slepc_pkg::*;
	logic              clk_i       = 1'b0;
	logic              rst_i       = 1'b1;
	logic              cyc_i       = 1'b0;
	logic              stb_i       = 1'b0;
	logic              we_i        = 1'b0;
	logic [15:0]       adr_i       = 16'h0000;
	logic [31:0]       dat_i       = 32'h0000_0000;
	logic              lock_loss_i = 1'b0;
	logic              ce_i        = 1'b1;
	logic [3:0]        sel_i       = 4'hF;
	logic [31:0]       dat_o;
	logic              ack_o;
	logic              pll_cal_reset_o;
	logic              startup_reset_o;
	logic              lock_lost_flag_o;
	logic              irq_o;
	slepc_lane_s [LANES-1:0] lane_cfg_o;
	logic [13:0]       lane_idx [4] = '{IDX_LANE0, IDX_LANE1, IDX_LANE2, IDX_LANE3};
	logic [31:0]       q;
	logic [7:0]        r;
	int                errors      = 0;
	int                total_checks = 0;
	int                seed        = 63;
	always #25 clk_i = ~clk_i;
	slepc_bank uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.lock_loss_i(lock_loss_i), .pll_cal_reset_o(pll_cal_reset_o),
		.startup_reset_o(startup_reset_o), .lock_lost_flag_o(lock_lost_flag_o),
		.lane_cfg_o(lane_cfg_o), .irq_o(irq_o));
	task automatic report_and_stop;
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	// one classic cycle; read data is taken at the edge that sees ack
	task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h000000, d};
		for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk_i);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		if (n == 20) begin
			errors++;
			report_and_stop();
		end
		@(posedge clk_i);
	endtask : bus
	task automatic settle;
		repeat (2) @(posedge clk_i);
		#1;
	endtask : settle
	task automatic rd(input string nm, input logic [13:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK(nm, {24'h000000, e}, q)
	endtask : rd
	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
		settle();
	endtask : wr
	task automatic pulse;
		@(posedge clk_i);
		lock_loss_i <= 1'b1;
		@(posedge clk_i);
		lock_loss_i <= 1'b0;
		settle();
	endtask : pulse
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK("startup", 1'b1, startup_reset_o)
		`CHK("cal", 1'b0, pll_cal_reset_o)
		`CHK("flag", 1'b0, lock_lost_flag_o)
		for (int i = 0; i < 4; i++) rd("lane rst", lane_idx[i], LANE_RSTVAL);
		rd("cal rst", IDX_PLL_CAL, CODE_NORMAL);
		rd("start rst", IDX_START, START_RSTVAL);
		rd("lol rst", IDX_LOL, CODE_NORMAL);
		rd("unmapped", 14'h0001, 8'h00);
		for (int k = 0; k < 12; k++) begin
			r = 8'($random(seed));
			r[6:4] = (k < 5) ? 3'(k) : 3'(r % 5);
			wr(lane_idx[k % 4], r);
			`CHK("lane cfg", {r[7], r[6:4]}, lane_cfg_o[k % 4])
			rd("lane back", lane_idx[k % 4], r);
		end
		wr(IDX_PLL_CAL, CAL_RESET);
		`CHK("cal on", 1'b1, pll_cal_reset_o)
		wr(IDX_START, START_RESET);
		`CHK("start on", 1'b1, startup_reset_o)
		wr(IDX_LANE0, 8'h10);
		`CHK("cal held", 1'b1, pll_cal_reset_o)
		wr(IDX_PLL_CAL, CODE_NORMAL);
		`CHK("cal off", 1'b0, pll_cal_reset_o)
		wr(IDX_START, CODE_NORMAL);
		`CHK("start off", 1'b0, startup_reset_o)
		wr(IDX_IRQ_MSK, 8'h01);
		pulse();
		`CHK("flag set", 1'b1, lock_lost_flag_o)
		`CHK("irq on", 1'b1, irq_o)
		wr(IDX_LOL, LOL_CLEAR);
		`CHK("flag clr", 1'b0, lock_lost_flag_o)
		rd("flag rd", IDX_FLAG, 8'h00);
		wr(IDX_LOL, CODE_NORMAL);
		pulse();
		settle();
		`CHK("flag again", 1'b1, lock_lost_flag_o)
		wr(IDX_IRQ_STS, 8'h03);
		`CHK("irq clr", 1'b0, irq_o)
		wr(IDX_IRQ_MSK, 8'h00);
		pulse();
		`CHK("irq masked", 1'b0, irq_o)
		rd("sts", IDX_IRQ_STS, 8'h01);
		wr(IDX_PLL_CAL, 8'h05);
		`CHK("cal odd", 1'b0, pll_cal_reset_o)
		rd("sts bad", IDX_IRQ_STS, 8'h03);
		wr(IDX_PLL_CAL, CODE_NORMAL);
		// byte lane zero off: the write is acked but must not land
		sel_i <= 4'h0;
		wr(IDX_PLL_CAL, CAL_RESET);
		sel_i <= 4'hF;
		`CHK("cal sel", 1'b0, pll_cal_reset_o)
		wr(IDX_LOL, LOL_CLEAR);
		wr(IDX_LOL, CODE_NORMAL);
		// enable low freezes the sticky flag
		@(posedge clk_i);
		ce_i <= 1'b0;
		pulse();
		`CHK("flag frozen", 1'b0, lock_lost_flag_o)
		@(posedge clk_i);
		ce_i <= 1'b1;
		settle();
		`CHK("flag still", 1'b0, lock_lost_flag_o)
		report_and_stop();
	end
endmodule : tb
